// ---- core/dsip_pkg.sv ----
`default_nettype none
package dsip_pkg;
   // frame lengths of the two shift register variants
   localparam int unsigned DSIP_LONG_BITS  = 24;
   localparam int unsigned DSIP_SHORT_BITS = 16;
   localparam int unsigned DSIP_CNT_W      = 5;
   // msb position of the short frame word
   localparam int unsigned DSIP_SHORT_MSB  = 15;
   // reset values
   localparam logic [23:0] DSIP_SHIFT_RST  = 24'h000000;
   localparam logic [23:0] DSIP_DAC_RST    = 24'h000000;
   localparam logic [4:0]  DSIP_CNT_RST    = 5'h00;
   // serial clock limits on the host side, in mhz
   localparam int unsigned DSIP_SCLK_MAX_HI_MHZ = 30;
   localparam int unsigned DSIP_SCLK_MAX_LO_MHZ = 20;
   localparam int unsigned DSIP_FIFO_DEPTH = 4;
   localparam int unsigned DSIP_FIFO_WIDTH = 24;
   typedef enum logic [1:0] {DSIP_IDLE, DSIP_SHIFT, DSIP_DONE} dsip_state_type;
endpackage
`default_nettype wire

// ---- core/dsip_serial_port.sv ----
// Contract
// [RULE_01] low frame sync enables shift register
// [RULE_02] capture data on serial clock falls
// [RULE_03] register width 24 or 16 bits
// [RULE_04] load dac after final clock
// [RULE_05] early sync rise discards partial frame
// [RULE_06] short frame msb is word bit fifteen
// [RULE_07] host keeps serial clock under limit
// [RULE_08] dac word is straight binary
// [RULE_09] ignore clocks when idle, restart count
`timescale 1ns/10ps
`default_nettype none

module dsip_fifo #(
   parameter int unsigned WIDTH = 24,
   parameter int unsigned DEPTH = 4
) (
   input  wire logic             clk,
   input  wire logic             sys_rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic             do_wr;
   logic             do_rd;

   // handshake terms
   assign in_ready  = (count_r != (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
   assign out_valid = (count_r != '0);
   assign do_wr     = in_valid & in_ready;
   assign do_rd     = out_valid & out_ready;
   assign out_data  = mem_r[rd_ptr_r];

   // storage write
   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + AW'(1);
         end
         if (do_rd) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + AW'(1);
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + (AW+1)'(1);
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - (AW+1)'(1);
         end
      end
   end
endmodule

module dsip_serial_port
   import dsip_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        long_variant,
   input  wire logic        sync_n,
   input  wire logic        sclk,
   input  wire logic        din,
   output logic [23:0]      dac_code,
   output logic             dac_update,
   output logic             frame_abort
);
   logic [2:0]     sync_n_sy_r;
   logic [2:0]     sclk_sy_r;
   logic [2:0]     din_sy_r;
   logic           sclk_fall;
   logic           sync_rise;
   logic           sync_fall;
   logic           frame_act;
   logic [23:0]    shift_r;
   logic [4:0]     cnt_r;
   logic [4:0]     frame_len;
   dsip_state_type state_r;
   logic           push_valid;
   logic [23:0]    push_data;
   logic           pop_valid;
   logic [23:0]    pop_data;
   logic [23:0]    dac_code_r;
   logic           dac_update_r;
   logic           frame_abort_r;

   // two-stage synchronisers plus one edge-history stage
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         sync_n_sy_r <= 3'h7;
         sclk_sy_r   <= 3'h7;
         din_sy_r    <= 3'h0;
      end else begin
         sync_n_sy_r <= {sync_n_sy_r[1:0], sync_n};
         sclk_sy_r   <= {sclk_sy_r[1:0], sclk};
         din_sy_r    <= {din_sy_r[1:0], din};
      end
   end

   // edge detection on synchronised copies only
   assign sclk_fall = sclk_sy_r[2] & ~sclk_sy_r[1];
   assign sync_rise = ~sync_n_sy_r[2] & sync_n_sy_r[1];
   assign sync_fall = sync_n_sy_r[2] & ~sync_n_sy_r[1];
   // [RULE_01] frame active level
   assign frame_act = ~sync_n_sy_r[1];
   // [RULE_03] variant frame length
   assign frame_len = long_variant ? DSIP_CNT_W'(DSIP_LONG_BITS) : DSIP_CNT_W'(DSIP_SHORT_BITS);

   // frame state machine
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_r <= DSIP_IDLE;
      end else begin
         case (state_r)
            DSIP_IDLE: begin
               // [RULE_09] restart on sync fall
               if (sync_fall) begin
                  state_r <= DSIP_SHIFT;
               end
            end
            DSIP_SHIFT: begin
               // [RULE_05] early rise aborts
               if (!frame_act) begin
                  state_r <= DSIP_IDLE;
               end else if (sclk_fall && cnt_r == frame_len - DSIP_CNT_W'(1)) begin
                  state_r <= DSIP_DONE;
               end
            end
            DSIP_DONE: begin
               // extra clocks ignored until sync rises
               if (!frame_act) begin
                  state_r <= DSIP_IDLE;
               end
            end
            default: begin
               state_r <= DSIP_IDLE;
            end
         endcase
      end
   end

   // bit counter and shift register
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_r   <= DSIP_CNT_RST;
         shift_r <= DSIP_SHIFT_RST;
      end else if (state_r == DSIP_IDLE) begin
         // [RULE_09] count cleared while idle
         cnt_r <= DSIP_CNT_RST;
      end else if (state_r == DSIP_SHIFT && frame_act && sclk_fall) begin
         // [RULE_02] capture on falling edge
         shift_r <= {shift_r[22:0], din_sy_r[1]};
         cnt_r   <= cnt_r + DSIP_CNT_W'(1);
      end
   end

   // [RULE_04] word complete pushes to fifo
   assign push_valid = (state_r == DSIP_SHIFT) && frame_act && sclk_fall
                       && (cnt_r == frame_len - DSIP_CNT_W'(1));
   // [RULE_06] short word msb lands on bit fifteen
   assign push_data  = long_variant ? {shift_r[22:0], din_sy_r[1]}
                                    : {8'h00, shift_r[14:0], din_sy_r[1]};

   // fifo drains every cycle and never fills, so its ready is left open
   dsip_fifo #(
      .WIDTH (DSIP_FIFO_WIDTH),
      .DEPTH (DSIP_FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .in_valid  (push_valid),
      .in_ready  (),
      .in_data   (push_data),
      .out_valid (pop_valid),
      .out_ready (1'b1),
      .out_data  (pop_data)
   );

   // [RULE_08] dac register holds straight binary code
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dac_code_r   <= DSIP_DAC_RST;
         dac_update_r <= 1'b0;
      end else begin
         dac_update_r <= pop_valid;
         if (pop_valid) begin
            dac_code_r <= pop_data;
         end
      end
   end

   // [RULE_05] abort pulse on early sync rise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         frame_abort_r <= 1'b0;
      end else begin
         frame_abort_r <= (state_r == DSIP_SHIFT) && sync_rise;
      end
   end

   assign dac_code    = dac_code_r;
   assign dac_update  = dac_update_r;
   assign frame_abort = frame_abort_r;
endmodule

`default_nettype wire

// ---- tb/dsip_serial_port_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsip_serial_port_monitor (
   input wire logic        clk,
   input wire logic        sys_rst,
   input wire logic        long_variant,
   input wire logic        sync_n,
   input wire logic [23:0] dac_code,
   input wire logic        dac_update,
   input wire logic        frame_abort
);
   // one clock domain, reset masks all
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   upd_pulse_a: assert property (dac_update |=> !dac_update) else $error("long update");
   abt_pulse_a: assert property (frame_abort |=> !frame_abort) else $error("long abort");
   abt_excl_a: assert property (!(dac_update && frame_abort)) else $error("both pulses");
   code_hold_a: assert property ($changed(dac_code) |-> dac_update) else $error("code moved");
   abt_keep_a: assert property (frame_abort |-> $stable(dac_code)) else $error("abort wrote");
   short_top_a: assert property (dac_update && !long_variant |-> dac_code[23:16] == 8'h00) else $error("top");
   open_quiet_a: assert property ($fell(sync_n) |-> !dac_update [*8]) else $error("early");
   abt_sync_a: assert property (frame_abort |-> $past(sync_n)) else $error("abort in frame");
   cover property (dac_update && long_variant);
   cover property (dac_update && !long_variant);
   cover property (frame_abort);
endmodule
`default_nettype wire

// ---- tb/dsip_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsip_host_model (
   input  wire logic clk,
   output logic      sync_n,
   output logic      sclk,
   output logic      din
);
   // idle: sync high, clock parked high
   initial begin
      sync_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // msb first, 80 ns bits; clocks past n carry zero
   task automatic send(input logic [23:0] w, input int n, input int stop);
      sync_n <= 1'b0;
      for (int i = 0; i < stop; i++) begin
         din <= (i < n) ? w[n-1-i] : 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
      end
      din <= ~din;
      sync_n <= 1'b1;
      repeat (24) @(posedge clk);
   endtask
   // clocks while sync stays high
   task automatic stray(input int k);
      repeat (k) begin
         sclk <= 1'b0;
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/dsip_serial_port_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module dsip_serial_port_bench;
   import dsip_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic lv = 1'b1;
   logic sync_n;
   logic sclk;
   logic din;
   logic [23:0] code;
   logic upd;
   logic abt;
   logic [23:0] upd_cnt = 24'h000000;
   logic [23:0] abt_cnt = 24'h000000;
   int fail_count = 0;
   int checks_done = 0;
   // 10 ns clock
   initial forever #5 clk = ~clk;
   dsip_serial_port DUT (.clk(clk), .sys_rst(sys_rst), .long_variant(lv), .sync_n(sync_n),
      .sclk(sclk), .din(din), .dac_code(code), .dac_update(upd), .frame_abort(abt));
   dsip_host_model host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
   // count result pulses
   always @(posedge clk) begin
      if (upd === 1'b1) upd_cnt <= upd_cnt + 24'h000001;
      if (abt === 1'b1) abt_cnt <= abt_cnt + 24'h000001;
   end
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one frame; full frame updates, short one aborts
   task automatic run(input logic v, input logic [23:0] w, input int n, input int stop, input logic [23:0] exp);
      logic [23:0] u0;
      logic [23:0] a0;
      u0 = upd_cnt;
      a0 = abt_cnt;
      lv <= v;
      @(posedge clk);
      host.send(w, n, stop);
      chk(code, exp);
      chk(upd_cnt - u0, {23'h0, stop >= n});
      chk(abt_cnt - a0, {23'h0, stop < n});
   endtask
   task automatic t_long;
      run(1'b1, 24'hC35A96, DSIP_LONG_BITS, DSIP_LONG_BITS, 24'hC35A96);
   endtask
   task automatic t_short;
      run(1'b0, 24'h0080F1, DSIP_SHORT_BITS, DSIP_SHORT_BITS, 24'h0080F1);
   endtask
   task automatic t_abort;
      run(1'b1, 24'hFFFFFF, DSIP_LONG_BITS, DSIP_LONG_BITS - 1, 24'h0080F1);
   endtask
   task automatic t_idle;
      host.stray(6);
      run(1'b1, 24'h7FFFFF, DSIP_LONG_BITS, DSIP_LONG_BITS, 24'h7FFFFF);
   endtask
   // mid-run reset clears the dac register
   task automatic t_reset;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk(code, DSIP_DAC_RST);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk(code, DSIP_DAC_RST);
   endtask
   // clocks after a full short word are ignored
   task automatic t_extra;
      run(1'b0, 24'h00A53C, DSIP_SHORT_BITS, DSIP_SHORT_BITS + 2, 24'h00A53C);
   endtask
   // reset, then scenarios
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
      t_long;
      t_short;
      t_abort;
      t_idle;
      t_reset;
      t_extra;
      report_and_stop;
   end
   // hang guard
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      report_and_stop;
   end
endmodule
bind dsip_serial_port dsip_serial_port_monitor MON (.clk(clk), .sys_rst(sys_rst), .long_variant(long_variant),
   .sync_n(sync_n), .dac_code(dac_code), .dac_update(dac_update), .frame_abort(frame_abort));
`default_nettype wire
